// ### core/cfr_pkg.sv
package cfr_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] ADDR_DEV_ID = 8'h01;
    localparam logic [7:0] ADDR_SPEED = 8'h02;
    localparam logic [7:0] ADDR_PWR = 8'h08;
    localparam logic [7:0] ADDR_GCLK = 8'h09;
    localparam logic [7:0] ADDR_COMMIT = 8'hFF;

    // Values after reset
    localparam logic [7:0] RST_PORT_CFG = 8'h18;
    localparam logic [7:0] RST_PWR = 8'h00;
    localparam logic [7:0] RST_GCLK = 8'h01;
    localparam logic [7:0] RST_COMMIT = 8'h00;

    // Port configuration field positions, both nibbles
    localparam int POS_LSB_HI = 6;
    localparam int POS_SRST_HI = 5;
    localparam int POS_SRST_LO = 2;
    localparam int POS_LSB_LO = 1;

    // Other field positions and widths
    localparam int POS_XFER = 0;
    localparam int POS_DCS = 0;
    localparam int POS_SPEED = 4;
    localparam int PWR_W = 2;

    // Fixed read-only values; identifier is arbitrary
    localparam logic [7:0] DEVICE_ID = 8'h5A;
    localparam logic [1:0] SPEED_CODE = 2'h0;
    localparam logic [7:0] COMMIT_CODE = 8'h01;

    // Internal power mode codes
    typedef enum logic [1:0] {
        CFR_PWR_NORMAL,
        CFR_PWR_DOWN,
        CFR_PWR_STANDBY,
        CFR_PWR_RSVD
    } cfr_pwr_e;
endpackage

// ### core/cfr_shadow_reg.sv
// Shadow register with an active copy loaded only on commit
module cfr_shadow_reg #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    input wire logic commit,
    output logic [W-1:0] shadow,
    output logic [W-1:0] active
);
    // Host side copy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow <= RST;
        end else if (wr) begin
            shadow <= wdata;
        end
    end

    // Copy seen by the converter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active <= RST;
        end else if (commit) begin
            active <= shadow;
        end
    end
endmodule

// ### core/cfr_config_regs.sv
// Function
// - Unmapped addresses and open bits have no function and read as zero.
// - Port config resets to 0x18; bit order and soft reset mirror both nibbles.
// - Power mode 00 normal, 01 full power-down, 10 standby, 11 reserved.
// - Power mode sits in bits 1:0, upper bits unused, resets to 0x00.
// - Shadowed writes act only after 0x01 written to 0xFF, all together.
// - Transfer bit triggers the shadow-to-active update, then clears itself.
module cfr_config_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic lsb_first,
    output logic soft_reset,
    output logic pwr_down,
    output logic pwr_standby,
    output logic dcs_en,
    output logic commit_done
);
    import cfr_pkg::*;

    logic [7:0] port_cfg;
    logic xfer;
    logic [PWR_W-1:0] pwr_shadow;
    logic [PWR_W-1:0] pwr_active;
    logic gclk_shadow;
    logic gclk_active;
    logic [7:0] next_rdata;

    // Address decode
    wire hit_cfg = reg_addr == ADDR_PORT_CFG;
    wire hit_id = reg_addr == ADDR_DEV_ID;
    wire hit_speed = reg_addr == ADDR_SPEED;
    wire hit_pwr = reg_addr == ADDR_PWR;
    wire hit_gclk = reg_addr == ADDR_GCLK;
    wire hit_commit = reg_addr == ADDR_COMMIT;
    wire mapped = hit_cfg | hit_id | hit_speed | hit_pwr | hit_gclk | hit_commit;

    // Write strobes; identifier and speed grade have none
    wire wr_cfg = reg_wr & hit_cfg;
    wire wr_pwr = reg_wr & hit_pwr;
    wire wr_gclk = reg_wr & hit_gclk;
    wire wr_xfer = reg_wr & hit_commit & (reg_wdata == COMMIT_CODE);

    // Mirrored flags decode in either shift order
    wire in_lsb = reg_wdata[POS_LSB_HI] | reg_wdata[POS_LSB_LO];
    wire in_srst = reg_wdata[POS_SRST_HI] | reg_wdata[POS_SRST_LO];
    wire srst_now = port_cfg[POS_SRST_HI];

    // Normalised port configuration byte, open bits forced
    wire [7:0] cfg_word = {1'b0, in_lsb, in_srst, 2'b11, in_srst, in_lsb, 1'b0};
    wire [7:0] cfg_clr = {port_cfg[7:6], 1'b0, port_cfg[4:3], 1'b0, port_cfg[1:0]};

    // Power mode decode
    wire is_down = cfr_pwr_e'(pwr_active) == CFR_PWR_DOWN;
    wire is_stby = cfr_pwr_e'(pwr_active) == CFR_PWR_STANDBY;

    // Read data mux; open bits and unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (hit_cfg) begin
            next_rdata = port_cfg;
        end else if (hit_id) begin
            next_rdata = DEVICE_ID;
        end else if (hit_speed) begin
            next_rdata = 8'(SPEED_CODE) << POS_SPEED;
        end else if (hit_pwr) begin
            next_rdata = 8'(pwr_shadow);
        end else if (hit_gclk) begin
            next_rdata = 8'(gclk_shadow) << POS_DCS;
        end else if (hit_commit) begin
            next_rdata = 8'(xfer) << POS_XFER;
        end
    end

    // Port configuration; soft reset bits clear themselves after one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_cfg <= RST_PORT_CFG;
        end else if (wr_cfg) begin
            port_cfg <= cfg_word;
        end else if (srst_now) begin
            port_cfg <= cfg_clr;
        end
    end

    // Transfer bit: set by the command, cleared after the update
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xfer <= RST_COMMIT[POS_XFER];
        end else if (wr_xfer) begin
            xfer <= 1'b1;
        end else if (xfer) begin
            xfer <= 1'b0;
        end
    end

    // Shadowed power mode, only the low field is stored
    cfr_shadow_reg #(
        .W(PWR_W),
        .RST(RST_PWR[PWR_W-1:0])
    ) u_pwr (
        .clk(clk),
        .rst_n(rst_n),
        .wr(wr_pwr),
        .wdata(reg_wdata[PWR_W-1:0]),
        .commit(xfer),
        .shadow(pwr_shadow),
        .active(pwr_active)
    );

    // Shadowed duty cycle stabilizer enable
    cfr_shadow_reg #(
        .W(1),
        .RST(RST_GCLK[POS_DCS])
    ) u_gclk (
        .clk(clk),
        .rst_n(rst_n),
        .wr(wr_gclk),
        .wdata(reg_wdata[POS_DCS]),
        .commit(xfer),
        .shadow(gclk_shadow),
        .active(gclk_active)
    );

    // Read port and registered outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            lsb_first <= 1'b0;
            soft_reset <= 1'b0;
            pwr_down <= 1'b0;
            pwr_standby <= 1'b0;
            dcs_en <= RST_GCLK[POS_DCS];
            commit_done <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
            lsb_first <= port_cfg[POS_LSB_HI];
            soft_reset <= srst_now;
            pwr_down <= is_down;
            pwr_standby <= is_stby;
            dcs_en <= gclk_active;
            commit_done <= xfer;
        end
    end

    unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && !mapped |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    cfg_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
        port_cfg[POS_LSB_HI] == port_cfg[POS_LSB_LO]
        && port_cfg[POS_SRST_HI] == port_cfg[POS_SRST_LO] && port_cfg[4:3] == 2'b11)
        else $error("port config nibbles differ");

    pwr_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 pwr_down == ($past(pwr_active) == 2'b01)
        && pwr_standby == ($past(pwr_active) == 2'b10))
        else $error("power mode decode wrong");

    pwr_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && hit_pwr |=> reg_rdata[7:2] == 6'h00)
        else $error("power mode upper bits set");

    shadow_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !xfer |=> $stable(pwr_active))
        else $error("active changed without commit");

    commit_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_xfer |=> xfer ##1 !xfer && pwr_active == $past(pwr_shadow)
        && gclk_active == $past(gclk_shadow))
        else $error("commit did not load and clear");

    id_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && hit_id |=> reg_rdata == DEVICE_ID)
        else $error("identifier read wrong");

    speed_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && hit_speed |=> reg_rdata == 8'h00)
        else $error("speed grade read wrong");

    // Clock enable copy moves only on the transfer bit
    gclk_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !xfer |=> $stable(gclk_active))
        else $error("clock control changed without commit");

    bad_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && hit_commit && reg_wdata != COMMIT_CODE && !xfer |=> !xfer)
        else $error("transfer set by wrong code");

    xfer_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        xfer && !wr_xfer |=> !xfer)
        else $error("transfer bit did not clear");

    commit_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        xfer |=> commit_done)
        else $error("commit pulse missing");

    pwr_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && hit_pwr |=> reg_rdata[PWR_W-1:0] == $past(pwr_shadow))
        else $error("power mode read-back wrong");

    // Soft reset flag clears itself and pulses once
    srst_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        port_cfg[POS_SRST_HI] && !wr_cfg |=> !port_cfg[POS_SRST_HI] && !port_cfg[POS_SRST_LO])
        else $error("soft reset flag stuck");

    srst_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        port_cfg[POS_SRST_HI] |=> soft_reset)
        else $error("soft reset pulse missing");

    srst_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !port_cfg[POS_SRST_HI] |=> !soft_reset)
        else $error("soft reset pulse without flag");
endmodule

// ### tb/cfr_host.sv
// Serial host stand-in: byte-level register accesses, driven on falling edges
module cfr_host (
    input wire logic clk,
    input wire logic reg_rvalid,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import cfr_pkg::*;

    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One write byte; released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // One read byte; a missing valid pulse yields unknown data
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask

    // Transfer command that commits all shadowed settings
    task automatic commit();
        wr(ADDR_COMMIT, COMMIT_CODE);
    endtask
endmodule

// ### tb/cfr_config_regs_tb_top.sv
// Top bench: register sequences against the configuration bank
module cfr_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cfr_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, lsb_first, soft_reset;
    logic pwr_down, pwr_standby, dcs_en, commit_done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int miscompares = 0;
    int tests_run = 0;
    int n_commit = 0;
    int n_srst = 0;

    always #2.5 clk = ~clk;

    cfr_config_regs i_cfr_config_regs (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lsb_first(lsb_first),
        .soft_reset(soft_reset), .pwr_down(pwr_down), .pwr_standby(pwr_standby),
        .dcs_en(dcs_en), .commit_done(commit_done));

    cfr_host i_cfr_host (.clk(clk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // Pulse counters for commit and soft reset
    always @(posedge clk) begin
        if (commit_done === 1'b1) n_commit++;
        if (soft_reset === 1'b1) n_srst++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_cfr_host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rchk(ADDR_PORT_CFG, 8'h18);
        rchk(ADDR_DEV_ID, DEVICE_ID);
        rchk(ADDR_SPEED, {2'b00, SPEED_CODE, 4'h0});
        rchk(ADDR_PWR, 8'h00);
        rchk(ADDR_GCLK, 8'h01);
        rchk(ADDR_COMMIT, 8'h00);
        chk({4'h0, lsb_first, pwr_down, pwr_standby, dcs_en}, 8'h01);
        done("reset");
        i_cfr_host.wr(ADDR_DEV_ID, 8'hFF);
        i_cfr_host.wr(ADDR_SPEED, 8'hFF);
        i_cfr_host.wr(8'h03, 8'h55);
        rchk(ADDR_DEV_ID, DEVICE_ID);
        rchk(ADDR_SPEED, {2'b00, SPEED_CODE, 4'h0});
        rchk(8'h03, 8'h00);
        rchk(8'h3C, 8'h00);
        done("read_only");
        i_cfr_host.wr(ADDR_PORT_CFG, 8'h42);
        rchk(ADDR_PORT_CFG, 8'h5A);
        chk({7'h00, lsb_first}, 8'h01);
        i_cfr_host.wr(ADDR_PORT_CFG, 8'h00);
        rchk(ADDR_PORT_CFG, 8'h18);
        i_cfr_host.wr(ADDR_PORT_CFG, 8'h02);
        rchk(ADDR_PORT_CFG, 8'h5A);
        i_cfr_host.wr(ADDR_PORT_CFG, 8'h04);
        i_cfr_host.wr(ADDR_PORT_CFG, 8'h20);
        rchk(ADDR_PORT_CFG, 8'h18);
        chk({7'h00, lsb_first}, 8'h00);
        chk(8'(n_srst), 8'h02);
        done("port_config");
        i_cfr_host.wr(ADDR_GCLK, 8'hFE);
        rchk(ADDR_GCLK, 8'h00);
        i_cfr_host.wr(ADDR_COMMIT, 8'h03);
        repeat (3) @(negedge clk);
        chk({7'h00, dcs_en}, 8'h01);
        chk(8'(n_commit), 8'h00);
        for (int c = 0; c < 4; c++) begin
            chk({6'h00, pwr_standby, pwr_down}, {6'h00, c == 3, c == 2});
            i_cfr_host.wr(ADDR_PWR, {6'h3F, 2'(c)});
            rchk(ADDR_PWR, {6'h00, 2'(c)});
            i_cfr_host.commit();
            repeat (3) @(negedge clk);
            chk({6'h00, pwr_standby, pwr_down}, {6'h00, c == 2, c == 1});
            rchk(ADDR_COMMIT, 8'h00);
        end
        chk({7'h00, dcs_en}, 8'h00);
        chk(8'(n_commit), 8'h04);
        done("commit");
        end_of_test();
    end

    // Watchdog against a hung sequence
    initial begin
        #20us;
        miscompares++;
        end_of_test();
    end
endmodule
